//--- hw/tpt_top.sv
`timescale 1ns/1ps
module tpt_top #(
  parameter int NVAL = 20,
  parameter int NORM_PAGES = 4,
  parameter int HIDE_PAGES = 3,
  parameter int HOLD_CYC = tpt_pkg::HOLD_CYCLES,
  parameter int IDLE_CYC = tpt_pkg::IDLE_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Panel controls, asynchronous
  input wire logic touch_any,
  input wire logic touch_centre,
  input wire logic icon_next,
  input wire logic icon_prev,
  input wire logic left_up,
  input wire logic left_down,
  input wire logic right_up,
  input wire logic right_down,
  // Sensor readings, signed tenths of a degree
  input wire logic [15:0] sensor_in_first,
  input wire logic [15:0] sensor_in_second,
  // Display state
  output logic disp_active,
  output logic [4:0] disp_left_idx,
  output logic [4:0] disp_right_idx,
  output logic [3:0] backlight,
  output logic [7:0] icon_show,
  output logic [7:0] icon_dim,
  output logic [3:0] alert_mask,
  output logic [63:0] colours,
  // Drive outputs
  output logic drive_out_first,
  output logic drive_out_second
);
  localparam int RAW_W = 8;
  logic [RAW_W-1:0] raw, s1_q, s2_q, prev_q;
  logic [31:0] tin1_q, tin2_q, tin1_s, tin2_s;
  assign raw = {right_down, right_up, left_down, left_up,
                icon_prev, icon_next, touch_centre, touch_any};
  // Two-flop synchronisers for panel inputs; sensor readings pass through four flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      prev_q <= '0;
      tin1_q <= '0;
      tin2_q <= '0;
      tin1_s <= '0;
      tin2_s <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      prev_q <= s2_q;
      tin1_q <= {sensor_in_second, sensor_in_first};
      tin1_s <= tin1_q;
      tin2_q <= tin1_s;
      tin2_s <= tin2_q;
    end
  end
  wire [RAW_W-1:0] press = s2_q & ~prev_q;
  wire any_press = |press;
  // Registers
  logic [31:0] ctrl_q;
  logic [7:0] bact_q, bidle_q;
  logic [7:0] theme_q;
  logic [31:0] col01_q, col23_q, offs_q;
  logic [15:0] setp_q, floor_q;
  logic [4:0] vsel_q;
  logic [15:0] vcfg_q [NVAL];
  logic [31:0] vlim_q [NVAL];
  logic [31:0] valm_q [NVAL];
  logic [15:0] vval_q [NVAL];
  // Store only at the edge that completes the access
  wire wr = psel && penable && pwrite && pready;
  wire rd_ok = paddr <= tpt_pkg::OFF_VVAL && paddr[1:0] == 2'b00;
  wire [4:0] vs = vsel_q;
  // Calibrated temperatures
  wire signed [15:0] t1 = $signed(tin2_s[15:0]) + $signed(offs_q[15:0]);
  wire signed [15:0] t2 = $signed(tin2_s[31:16]) + $signed(offs_q[31:16]);
  // Display state machine and paging
  tpt_pkg::tpt_state_t st_q;
  logic [4:0] page_q;
  logic hid_q, setup_q;
  logic [31:0] hold_q, idle_q;
  wire [4:0] npages = 5'(NORM_PAGES + (hid_q ? HIDE_PAGES : 0) +
                         (setup_q ? NVAL / 2 - NORM_PAGES - HIDE_PAGES : 0));
  wire [4:0] li = 5'({page_q, 1'b0});
  wire [4:0] ri = 5'(li + 5'd1);
  wire can_next = 5'(page_q + 5'd1) < npages;
  wire can_prev = page_q != 5'd0;
  wire last_norm = page_q == 5'(NORM_PAGES - 1) && !hid_q;
  wire last_hid = page_q == 5'(NORM_PAGES + HIDE_PAGES - 1) && hid_q && !setup_q;
  wire hold_next = s2_q[2] && last_norm;
  wire hold_ctr = s2_q[1] && last_hid;
  wire act = st_q == tpt_pkg::TPT_ST_ACTIVE;
  wire adj_l = vcfg_q[li][tpt_pkg::VCFG_ADJ];
  wire adj_r = vcfg_q[ri][tpt_pkg::VCFG_ADJ];
  function automatic logic [15:0] step(input logic [15:0] v, input logic [31:0] lim,
                                        input logic up, input logic dn);
    logic signed [15:0] nv;
    nv = $signed(v);
    if (up && $signed(v) < $signed(lim[31:16])) nv = $signed(v) + 16'sd1;
    if (dn && $signed(v) > $signed(lim[15:0])) nv = $signed(v) - 16'sd1;
    return nv;
  endfunction
  wire do_l = act && adj_l && (press[4] | press[5]);
  wire do_r = act && adj_r && (press[6] | press[7]);
  wire [15:0] new_l = step(vval_q[li], vlim_q[li], press[4], press[5]);
  wire [15:0] new_r = step(vval_q[ri], vlim_q[ri], press[6], press[7]);
  wire top_l = !($signed(vval_q[li]) < $signed(vlim_q[li][31:16]));
  wire bot_l = !($signed(vval_q[li]) > $signed(vlim_q[li][15:0]));
  wire top_r = !($signed(vval_q[ri]) < $signed(vlim_q[ri][31:16]));
  wire bot_r = !($signed(vval_q[ri]) > $signed(vlim_q[ri][15:0]));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= tpt_pkg::TPT_ST_IDLE;
      page_q <= '0;
      hid_q <= 1'b0;
      setup_q <= 1'b0;
      hold_q <= '0;
      idle_q <= '0;
    end else begin
      unique case (st_q)
        tpt_pkg::TPT_ST_IDLE: begin
          page_q <= '0;
          if (any_press) st_q <= tpt_pkg::TPT_ST_ACTIVE;
          idle_q <= '0;
        end
        tpt_pkg::TPT_ST_ACTIVE: begin
          idle_q <= any_press ? 32'd0 : idle_q + 32'd1;
          // Page drops with the state so idle never shows a stale pair
          if (idle_q >= 32'(IDLE_CYC)) begin
            st_q <= tpt_pkg::TPT_ST_IDLE;
            page_q <= '0;
          end else if (press[2] && can_next) page_q <= page_q + 5'd1;
          else if (press[3] && can_prev) page_q <= page_q - 5'd1;
        end
      endcase
      // Hold counters restart on any release, so the press must be continuous
      if (act && (hold_next || hold_ctr)) begin
        if (hold_q >= 32'(HOLD_CYC - 1)) begin
          hid_q <= hid_q | hold_next;
          setup_q <= setup_q | hold_ctr;
          hold_q <= '0;
        end else hold_q <= hold_q + 32'd1;
      end else hold_q <= '0;
    end
  end
  // Alarm per displayed value
  function automatic logic out_alm(input logic [15:0] v, input logic [31:0] a);
    return $signed(v) > $signed(a[31:16]) || $signed(v) < $signed(a[15:0]);
  endfunction
  wire al_l = out_alm(vval_q[li], valm_q[li]);
  wire al_r = out_alm(vval_q[ri], valm_q[ri]);
  // Any alarmed value on a reachable page beyond this one, for the pointing icon
  logic al_fwd, al_back;
  always_comb begin
    al_fwd = 1'b0;
    al_back = 1'b0;
    for (int i = 0; i < NVAL; i++) begin
      if (5'(i) < 5'({npages, 1'b0}) && out_alm(vval_q[i], valm_q[i])) begin
        if (5'(i) > ri) al_fwd = 1'b1;
        if (5'(i) < li) al_back = 1'b1;
      end
    end
  end
  // Theme table; theme 0 is the custom set
  logic [63:0] theme_col;
  always_comb begin
    unique case (theme_q[1:0])
      2'd0: theme_col = {col23_q, col01_q};
      2'd1: theme_col = 64'hF800_07E0_FFFF_0000;
      2'd2: theme_col = 64'hF800_001F_0000_FFFF;
      default: theme_col = 64'hF800_8410_FFE0_2104;
    endcase
  end
  wire [3:0] b_act = bact_q[3:0] > tpt_pkg::BRIGHT_MAX ? tpt_pkg::BRIGHT_MAX : bact_q[3:0];
  wire [3:0] b_idle = bidle_q[3:0] > tpt_pkg::BRIGHT_MAX ? tpt_pkg::BRIGHT_MAX : bidle_q[3:0];
  // Thermostat with hysteresis
  wire [1:0] mode = ctrl_q[tpt_pkg::CTRL_MODE_LSB +: 2];
  wire signed [15:0] band = $signed({8'h00, ctrl_q[tpt_pkg::CTRL_HYST_LSB +: 8]});
  wire en1 = ctrl_q[tpt_pkg::CTRL_EN1];
  logic room_q, floor_ok_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      room_q <= 1'b0;
      floor_ok_q <= 1'b0;
    end else begin
      if (t1 < $signed(setp_q) - band) room_q <= 1'b1;
      else if (t1 >= $signed(setp_q)) room_q <= 1'b0;
      if (t2 < $signed(floor_q) - band) floor_ok_q <= 1'b1;
      else if (t2 >= $signed(floor_q)) floor_ok_q <= 1'b0;
    end
  end
  logic auto1;
  always_comb begin
    unique case (mode)
      tpt_pkg::TPT_MODE_ROOM: auto1 = en1 && room_q;
      tpt_pkg::TPT_MODE_ROOM_FLOOR: auto1 = en1 && room_q && floor_ok_q;
      default: auto1 = en1;
    endcase
  end
  // Register writes and local adjustment share storage
  wire sp_slot = vcfg_q[li][tpt_pkg::VCFG_TYPE_LSB +: 4] == 4'h1;
  wire sp_slot_r = vcfg_q[ri][tpt_pkg::VCFG_TYPE_LSB +: 4] == 4'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= tpt_pkg::CTRL_RST;
      bact_q <= tpt_pkg::BRIGHT_ACT_RST;
      bidle_q <= tpt_pkg::BRIGHT_IDLE_RST;
      theme_q <= '0;
      col01_q <= '0;
      col23_q <= '0;
      offs_q <= '0;
      setp_q <= tpt_pkg::SETP_RST;
      floor_q <= tpt_pkg::FLOOR_RST;
      vsel_q <= '0;
      for (int i = 0; i < NVAL; i++) begin
        vcfg_q[i] <= '0;
        vlim_q[i] <= '0;
        valm_q[i] <= '0;
        vval_q[i] <= '0;
      end
    end else begin
      if (do_l) vval_q[li] <= new_l;
      if (do_r) vval_q[ri] <= new_r;
      if (do_l && sp_slot) setp_q <= new_l;
      if (do_r && sp_slot_r) floor_q <= new_r;
      if (wr) begin
        unique case (paddr)
          tpt_pkg::OFF_CTRL: ctrl_q <= pwdata;
          tpt_pkg::OFF_BRIGHT: {bidle_q, bact_q} <= pwdata[15:0];
          tpt_pkg::OFF_THEME: theme_q <= pwdata[7:0];
          tpt_pkg::OFF_COL01: col01_q <= pwdata;
          tpt_pkg::OFF_COL23: col23_q <= pwdata;
          tpt_pkg::OFF_OFFS: offs_q <= pwdata;
          tpt_pkg::OFF_SETP: {floor_q, setp_q} <= pwdata;
          tpt_pkg::OFF_VSEL: vsel_q <= pwdata[4:0] < 5'(NVAL) ? pwdata[4:0] : 5'd0;
          tpt_pkg::OFF_VCFG: vcfg_q[vs] <= pwdata[15:0];
          tpt_pkg::OFF_VLIM: vlim_q[vs] <= pwdata;
          tpt_pkg::OFF_VALM: valm_q[vs] <= pwdata;
          tpt_pkg::OFF_VVAL: vval_q[vs] <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end
  // Read mux
  logic [31:0] rdat;
  always_comb begin
    unique case (paddr)
      tpt_pkg::OFF_CTRL: rdat = ctrl_q;
      tpt_pkg::OFF_BRIGHT: rdat = {16'h0000, bidle_q, bact_q};
      tpt_pkg::OFF_THEME: rdat = {24'h00_0000, theme_q};
      tpt_pkg::OFF_COL01: rdat = col01_q;
      tpt_pkg::OFF_COL23: rdat = col23_q;
      tpt_pkg::OFF_OFFS: rdat = offs_q;
      tpt_pkg::OFF_SETP: rdat = {floor_q, setp_q};
      tpt_pkg::OFF_TEMP: rdat = {t2, t1};
      tpt_pkg::OFF_STAT: rdat = {16'h0000, 3'b000, page_q, 3'b000, setup_q, hid_q,
                                 act, drive_out_second, drive_out_first};
      tpt_pkg::OFF_VSEL: rdat = {27'h000_0000, vsel_q};
      tpt_pkg::OFF_VCFG: rdat = {16'h0000, vcfg_q[vs]};
      tpt_pkg::OFF_VLIM: rdat = vlim_q[vs];
      tpt_pkg::OFF_VALM: rdat = valm_q[vs];
      tpt_pkg::OFF_VVAL: rdat = {16'h0000, vval_q[vs]};
      default: rdat = 32'h0000_0000;
    endcase
  end
  // Outputs, all registered; nothing here waits on the network
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      disp_active <= 1'b0;
      disp_left_idx <= '0;
      disp_right_idx <= '0;
      backlight <= '0;
      icon_show <= '0;
      icon_dim <= '0;
      alert_mask <= '0;
      colours <= '0;
      drive_out_first <= 1'b0;
      drive_out_second <= 1'b0;
    end else begin
      // One wait state: answer lands in the second access cycle
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !rd_ok;
      prdata <= (psel && penable && !pready && !pwrite && rd_ok) ? rdat : 32'h0000_0000;
      disp_active <= act;
      disp_left_idx <= li;
      disp_right_idx <= ri;
      backlight <= act ? b_act : b_idle;
      // Icons: [0]lu [1]ld [2]ru [3]rd [4]next [5]prev
      icon_show <= act ? {2'b00, 1'b1, 1'b1, adj_r, adj_r, adj_l, adj_l} : 8'h00;
      icon_dim <= act ? {2'b00, !can_prev, !can_next, bot_r, top_r, bot_l, top_l} : 8'h00;
      alert_mask <= {al_back, al_fwd, al_l || al_r, al_l || al_r};
      colours <= theme_col;
      drive_out_first <= ctrl_q[tpt_pkg::CTRL_FORCE1] ? ctrl_q[tpt_pkg::CTRL_FVAL1] : auto1;
      drive_out_second <= ctrl_q[tpt_pkg::CTRL_FORCE2] ? ctrl_q[tpt_pkg::CTRL_FVAL2]
                          : ctrl_q[tpt_pkg::CTRL_EN2];
    end
  end
endmodule

//--- pkg/tpt_pkg.sv
package tpt_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_BRIGHT = 12'h004;
  localparam logic [11:0] OFF_THEME = 12'h008;
  localparam logic [11:0] OFF_COL01 = 12'h00C;
  localparam logic [11:0] OFF_COL23 = 12'h010;
  localparam logic [11:0] OFF_OFFS = 12'h014;
  localparam logic [11:0] OFF_SETP = 12'h018;
  localparam logic [11:0] OFF_TEMP = 12'h01C;
  localparam logic [11:0] OFF_STAT = 12'h020;
  localparam logic [11:0] OFF_VSEL = 12'h024;
  localparam logic [11:0] OFF_VCFG = 12'h028;
  localparam logic [11:0] OFF_VLIM = 12'h02C;
  localparam logic [11:0] OFF_VALM = 12'h030;
  localparam logic [11:0] OFF_VVAL = 12'h034;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_EN1 = 2;
  localparam int CTRL_EN2 = 3;
  localparam int CTRL_FORCE1 = 4;
  localparam int CTRL_FORCE2 = 5;
  localparam int CTRL_FVAL1 = 6;
  localparam int CTRL_FVAL2 = 7;
  localparam int CTRL_HYST_LSB = 8;
  // Value config fields
  localparam int VCFG_ADJ = 0;
  localparam int VCFG_TYPE_LSB = 4;
  localparam int VCFG_LABEL_LSB = 8;
  // Reset values and brightness cap
  localparam logic [31:0] CTRL_RST = 32'h0000_020C;
  localparam logic [7:0] BRIGHT_ACT_RST = 8'h09;
  localparam logic [7:0] BRIGHT_IDLE_RST = 8'h03;
  localparam logic [3:0] BRIGHT_MAX = 4'h9;
  localparam logic [15:0] SETP_RST = 16'h00C8;
  localparam logic [15:0] FLOOR_RST = 16'h0118;
  // Hold time and idle timeout
  localparam int HOLD_MS = 10000;
  localparam int CLK_MHZ = 100;
  localparam int HOLD_CYCLES = HOLD_MS * 1000 * CLK_MHZ;
  // Kept under the 32-bit signed limit once scaled to cycles
  localparam int IDLE_MS = 20000;
  localparam int IDLE_CYCLES = IDLE_MS * 1000 * CLK_MHZ;
  typedef enum logic [1:0] {
    TPT_MODE_NONE = 2'h0,
    TPT_MODE_ROOM = 2'h1,
    TPT_MODE_ROOM_FLOOR = 2'h2
  } tpt_mode_t;
  typedef enum logic [1:0] {
    TPT_ST_IDLE = 2'b01,
    TPT_ST_ACTIVE = 2'b10
  } tpt_state_t;
endpackage

//--- test/tpt_monitor.sv
`timescale 1ns/1ps
module tpt_monitor (
  // Clock, reset, bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Panel and drives
  input wire logic touch_any,
  input wire logic disp_active,
  input wire logic [4:0] disp_left_idx,
  input wire logic [3:0] backlight,
  input wire logic drive_out_first,
  input wire logic drive_out_second
);
  // Shadow of control word, taken at the storing edge
  logic [31:0] ctrl_q;
  logic [1:0] age_q;
  wire wr_ctrl = psel && penable && pwrite && pready && paddr == tpt_pkg::OFF_CTRL;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= tpt_pkg::CTRL_RST;
      age_q <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata;
      end
      if (age_q != 2'h3) begin
        age_q <= age_q + 2'h1;
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_wake;
    $rose(touch_any) ##0 !disp_active;
  endsequence
  // Output settles well inside four cycles of a control change
  sequence s_calm;
    age_q == 2'h3 && ctrl_q == $past(ctrl_q, 4);
  endsequence
  a_ready_next: assert property (s_access |=> pready)
    else $error("pready missing after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_hole: assert property (s_access ##0 (paddr > 12'h034) |=> pslverr)
    else $error("no error for unmapped address");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  a_idle_first: assert property (age_q == 2'h3 && !disp_active |-> disp_left_idx == 5'h00)
    else $error("idle not on first value");
  a_bright_cap: assert property (backlight <= 4'h9)
    else $error("backlight above nine");
  a_wake_touch: assert property (s_wake |-> ##[1:5] disp_active)
    else $error("touch did not wake panel");
  a_out_two: assert property (s_calm |-> drive_out_second == (ctrl_q[5] ? ctrl_q[7] : ctrl_q[3]))
    else $error("second drive wrong");
  a_out_manual: assert property (s_calm ##0 ctrl_q[1:0] == 2'h0 |->
    drive_out_first == (ctrl_q[4] ? ctrl_q[6] : ctrl_q[2]))
    else $error("first drive wrong in manual mode");
endmodule
bind tpt_top tpt_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .touch_any, .disp_active, .disp_left_idx, .backlight,
  .drive_out_first, .drive_out_second);

//--- test/tpt_remote_master.sv
`timescale 1ns/1ps
module tpt_remote_master (
  // Bus
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Answer never came
  output logic hung
);
  logic [31:0] rd_q;
  logic err_q;
  initial begin
    {psel, penable, pwrite, hung} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // Remote reads inputs and writes setpoints and drives
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 50);
    hung <= !pready;
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

//--- test/tpt_top_tb_top.sv
`timescale 1ns/1ps
module tpt_top_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, act, o1, o2;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  // any, centre, next, prev, left up, left down, right up, right down
  logic [7:0] btn = 8'h00;
  logic [15:0] s1 = 16'h0000;
  logic [15:0] s2 = 16'h0000;
  logic [4:0] li, ri;
  logic [3:0] bl, am;
  logic [7:0] ish, idm;
  logic [63:0] col;
  int bad_count = 0;
  int checks = 0;
  initial begin
    forever #5 pclk = ~pclk;
  end
  // Short hold and idle counts keep the run brief
  tpt_top #(.HOLD_CYC(20), .IDLE_CYC(200)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .touch_any(btn[0]), .touch_centre(btn[1]),
    .icon_next(btn[2]), .icon_prev(btn[3]), .left_up(btn[4]), .left_down(btn[5]),
    .right_up(btn[6]), .right_down(btn[7]), .sensor_in_first(s1), .sensor_in_second(s2),
    .disp_active(act), .disp_left_idx(li), .disp_right_idx(ri), .backlight(bl),
    .icon_show(ish), .icon_dim(idm), .alert_mask(am), .colours(col),
    .drive_out_first(o1), .drive_out_second(o2));
  tpt_remote_master u_m (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .hung());
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_m.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string w);
    u_m.xfer(1'b0, a, 32'h0000_0000);
    chk(w, u_m.rd_q, e);
  endtask
  // Held past the two-flop sync so each press is seen once
  task automatic press(input int b);
    btn[b] <= 1'b1;
    tick(4);
    btn[b] <= 1'b0;
    tick(6);
  endtask
  task automatic t_reset();
    tick(4);
    chk("active", 32'(act), 32'h0);
    chk("pair", 32'({li, ri}), 32'h1);
    chk("light", 32'(bl), 32'(tpt_pkg::BRIGHT_IDLE_RST));
    rd(tpt_pkg::OFF_CTRL, tpt_pkg::CTRL_RST, "ctrl");
    rd(12'h038, 32'h0000_0000, "hole");
    chk("err", 32'(u_m.err_q), 32'h1);
    chk("drives", 32'({o2, o1}), 32'h3);
  endtask
  task automatic t_sense();
    wr(tpt_pkg::OFF_OFFS, 32'hFFFD_0005);
    s1 <= 16'h00C8;
    s2 <= 16'h0064;
    tick(8);
    rd(tpt_pkg::OFF_TEMP, 32'h0061_00CD, "temp");
    wr(tpt_pkg::OFF_TEMP, 32'h0000_0000);
    rd(tpt_pkg::OFF_TEMP, 32'h0061_00CD, "temp ro");
    wr(tpt_pkg::OFF_OFFS, 32'h0000_0000);
    wr(tpt_pkg::OFF_SETP, 32'h0123_00AB);
    rd(tpt_pkg::OFF_SETP, 32'h0123_00AB, "setp");
    wr(tpt_pkg::OFF_SETP, 32'h0118_00C8);
  endtask
  // Ordered: hysteresis rows depend on the row before
  task automatic t_out();
    logic [63:0] tc [12] = '{64'h000C_00C8_0064_0003, 64'h0000_00C8_0064_0000,
      64'h0A0D_00B9_0064_0003, 64'h0A0D_00C3_0064_0003, 64'h0A0D_00C8_0064_0002,
      64'h0A0D_00C3_0064_0002, 64'h0A05_0064_0064_0001, 64'h0A01_0064_0064_0000,
      64'h0A0E_0064_0064_0003, 64'h0A0E_0064_0122_0002, 64'h001C_0064_0064_0002,
      64'h002C_0064_0064_0001};
    foreach (tc[i]) begin
      wr(tpt_pkg::OFF_CTRL, {16'h0000, tc[i][63:48]});
      s1 <= tc[i][47:32];
      s2 <= tc[i][31:16];
      tick(8);
      chk("drive", 32'({o2, o1}), 32'(tc[i][1:0]));
    end
  endtask
  task automatic t_panel();
    wr(tpt_pkg::OFF_BRIGHT, 32'h0000_030F);
    wr(tpt_pkg::OFF_COL01, 32'h1234_5678);
    wr(tpt_pkg::OFF_COL23, 32'h9ABC_DEF0);
    tick(2);
    chk("colours lo", col[31:0], 32'h1234_5678);
    chk("colours hi", col[63:32], 32'h9ABC_DEF0);
    wr(tpt_pkg::OFF_VSEL, 32'h0000_0003);
    wr(tpt_pkg::OFF_VCFG, 32'h0000_0000);
    wr(tpt_pkg::OFF_VVAL, 32'h0000_0007);
    wr(tpt_pkg::OFF_VSEL, 32'h0000_0002);
    wr(tpt_pkg::OFF_VCFG, 32'h0000_0001);
    wr(tpt_pkg::OFF_VLIM, 32'h0005_0000);
    wr(tpt_pkg::OFF_VALM, 32'h0003_0000);
    wr(tpt_pkg::OFF_VVAL, 32'h0000_0004);
    press(0);
    chk("woke", 32'({act, bl}), 32'h19);
    chk("paging", 32'({ish[5:4], idm[5]}), 32'h7);
    chk("route fwd", 32'(am[3:2]), 32'h1);
    press(2);
    chk("page1", 32'({li, ri}), 32'h43);
    chk("adj icons", 32'(ish[3:0]), 32'h3);
    chk("alarm", 32'(am[1:0]), 32'h3);
    press(4);
    press(4);
    rd(tpt_pkg::OFF_VVAL, 32'h0000_0005, "capped");
    chk("up dim", 32'(idm[1:0]), 32'h1);
    press(7);
    wr(tpt_pkg::OFF_VSEL, 32'h0000_0003);
    rd(tpt_pkg::OFF_VVAL, 32'h0000_0007, "fixed");
    press(2);
    press(2);
    chk("last dim", 32'(idm[4]), 32'h1);
    chk("route back", 32'(am[3:2]), 32'h2);
    btn[2] <= 1'b1;
    tick(30);
    btn[2] <= 1'b0;
    u_m.xfer(1'b0, tpt_pkg::OFF_STAT, 32'h0000_0000);
    chk("hidden", 32'(u_m.rd_q[3]), 32'h1);
    press(2);
    press(2);
    press(2);
    btn[1] <= 1'b1;
    tick(30);
    btn[1] <= 1'b0;
    rd(tpt_pkg::OFF_STAT, 32'h0000_061D, "setup");
    tick(250);
    chk("back idle", 32'({act, li}), 32'h0);
    chk("idle light", 32'(bl), 32'h3);
  endtask
  always @(posedge u_m.hung) begin
    bad_count++;
    complete_run();
  end
  initial begin
    tick(60000);
    bad_count++;
    complete_run();
  end
  initial begin
    tick(8);
    presetn <= 1'b1;
    t_reset();
    t_sense();
    t_out();
    t_panel();
    complete_run();
  end
endmodule
